// *** hw/dpm_pin_mux.sv ***
// module: debug port pin release mux between the combined_debug_port and gpio
`timescale 1ns/1ps
module dpm_pin_mux (
  // clocks and reset
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_link_clk,
  input  wire logic                        i_arst_n,
  // register port, system clock domain
  input  wire logic [dpm_pkg::AW-1:0]      i_reg_addr,
  input  wire logic [dpm_pkg::DW-1:0]      i_reg_wdata,
  input  wire logic                        i_reg_wr,
  input  wire logic                        i_reg_rd,
  output logic      [dpm_pkg::DW-1:0]      o_reg_rdata,
  // shared pads
  input  wire logic [dpm_pkg::NPIN-1:0]    i_pad_in,
  output dpm_pkg::dpm_pad_s                o_pad,
  // gpio controller, system clock domain
  input  wire dpm_pkg::dpm_pad_s           i_gpio,
  input  wire logic [dpm_pkg::NPIN-1:0]    i_gpio_cfg_valid,
  output logic      [dpm_pkg::NPIN-1:0]    o_gpio_in,
  // debug core, link clock domain except o_dbg_in and o_dbg_own, which come from the system clock
  input  wire dpm_pkg::dpm_core_s          i_dbg_core,
  output logic      [dpm_pkg::NPIN-1:0]    o_dbg_in,
  output logic      [dpm_pkg::NPIN-1:0]    o_dbg_own,
  output logic      [dpm_pkg::NPIN-1:0]    o_lk_pin_avail,
  output logic                             o_lk_trace_armed
);
  import dpm_pkg::*;

  dpm_ref_s  ref_reg;
  dpm_ref_s  ref_next;
  dpm_link_s lk_reg;
  dpm_link_s lk_next;

  // pins kept on the debug port for a release setting
  function automatic logic [NPIN-1:0] own_mask(input dpm_rel_e m);
    logic [NPIN-1:0] r;
    r = OWN_FULL;
    unique case (m)
      REL_FULL:     r = OWN_FULL;
      REL_NO_TRST:  r = OWN_NO_TRST;
      REL_SWD_ONLY: r = OWN_SWD_ONLY;
      REL_ALL:      r = OWN_NONE;
    endcase
    return r;
  endfunction

  // system-clock side: register port, pad synchronisers and the mux itself
  always_comb begin
    logic swd;
    swd = ref_reg.core_s2.swd_mode;
    ref_next = ref_reg;
    // level crossings; first stage feeds only the second
    ref_next.pad_s1  = i_pad_in;
    ref_next.pad_s2  = ref_reg.pad_s1;
    ref_next.core_s1 = i_dbg_core;
    ref_next.core_s2 = ref_reg.core_s1;
    // only the processor side reaches this port, the debugger has no write path
    if (i_reg_wr && i_reg_addr == ADDR_CTRL) begin
      ref_next.mode = dpm_rel_e'(i_reg_wdata[CTRL_MODE_LSB +: $bits(dpm_rel_e)]);
    end
    ref_next.own = own_mask(ref_reg.mode);
    // read data stands only in the cycle after the strobe
    ref_next.rdata = '0;
    if (i_reg_rd) begin
      if (i_reg_addr == ADDR_CTRL) begin
        ref_next.rdata[CTRL_MODE_LSB +: $bits(dpm_rel_e)] = ref_reg.mode;
      end else if (i_reg_addr == ADDR_STAT) begin
        ref_next.rdata[STAT_OWN_LSB +: NPIN] = ref_reg.own;
        ref_next.rdata[STAT_TRACE_BIT]       = ref_reg.core_s2.trace_en;
        ref_next.rdata[STAT_SWD_BIT]         = swd;
      end
    end
    // released pins: gpio drives, but holds its reset setup until configured
    for (int i = 0; i < NPIN; i++) begin
      if (i_gpio_cfg_valid[i]) begin
        ref_next.pad.out[i] = i_gpio.out[i];
        ref_next.pad.oe[i]  = i_gpio.oe[i];
        ref_next.pad.pu[i]  = i_gpio.pu[i];
        ref_next.pad.pd[i]  = i_gpio.pd[i];
      end else begin
        ref_next.pad.out[i] = 1'b0;
        ref_next.pad.oe[i]  = 1'b0;
        ref_next.pad.pu[i]  = GPIO_RST_PU[i];
        ref_next.pad.pd[i]  = GPIO_RST_PD[i];
      end
    end
    // debug-owned pins override gpio entirely, with fixed pulls
    for (int i = 0; i < NPIN; i++) begin
      if (ref_reg.own[i]) begin
        ref_next.pad.out[i] = 1'b0;
        ref_next.pad.oe[i]  = 1'b0;
        ref_next.pad.pu[i]  = DBG_PU[i];
        ref_next.pad.pd[i]  = DBG_PD[i];
      end
    end
    // mode/data pin is bidirectional only in two-wire mode
    if (ref_reg.own[PIN_A13] && swd) begin
      ref_next.pad.out[PIN_A13] = ref_reg.core_s2.swdio_out;
      ref_next.pad.oe[PIN_A13]  = ref_reg.core_s2.swdio_oe;
    end
    // data out floats when undriven, trace pin only drives once armed
    if (ref_reg.own[PIN_B3]) begin
      ref_next.pad.pu[PIN_B3] = 1'b0;
      ref_next.pad.pd[PIN_B3] = 1'b0;
      if (!swd) begin
        ref_next.pad.out[PIN_B3] = ref_reg.core_s2.tdo;
        ref_next.pad.oe[PIN_B3]  = 1'b1;
      end else if (ref_reg.core_s2.trace_en) begin
        ref_next.pad.out[PIN_B3] = ref_reg.core_s2.trace_out;
        ref_next.pad.oe[PIN_B3]  = 1'b1;
      end
    end
    // inputs to the debug core; released inputs sit at their idle pull level
    for (int i = 0; i < NPIN; i++) begin
      ref_next.dbg_in[i] = ref_reg.own[i] ? ref_reg.pad_s2[i] : DBG_IN_IDLE[i];
    end
    ref_next.gpio_in = ref_reg.pad_s2;
  end

  // system-clock state register
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ref_reg <= REF_RST;
    end else begin
      ref_reg <= ref_next;
    end
  end

  // link side: trace arming as the host programs it, pin availability crossing
  always_comb begin
    lk_next        = lk_reg;
    lk_next.trace  = i_dbg_core.trace_en & i_dbg_core.swd_mode;
    lk_next.own_s1 = ref_reg.own;
    lk_next.own_s2 = lk_reg.own_s1;
  end

  // link-clock state register; the link clock may stop between sessions
  always_ff @(posedge i_link_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lk_reg <= LINK_RST;
    end else begin
      lk_reg <= lk_next;
    end
  end

  // every output is a flop
  assign o_reg_rdata      = ref_reg.rdata;
  assign o_pad            = ref_reg.pad;
  assign o_gpio_in        = ref_reg.gpio_in;
  assign o_dbg_in         = ref_reg.dbg_in;
  assign o_dbg_own        = ref_reg.own;
  assign o_lk_pin_avail   = lk_reg.own_s2;
  assign o_lk_trace_armed = lk_reg.trace;

  // checks on the release setting reaching the ownership flags
  property p_full_owns_all;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      (i_reg_wr && i_reg_addr == ADDR_CTRL && i_reg_wdata[1:0] == 2'h0) ##1 (!i_reg_wr)
        |-> ##1 (o_dbg_own == 5'h1F);
  endproperty
  a_full_owns_all: assert property (p_full_owns_all) else $error("full setting did not keep all pins");

  property p_no_trst;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      (i_reg_wr && i_reg_addr == ADDR_CTRL && i_reg_wdata[1:0] == 2'h1) ##1 (!i_reg_wr)
        |-> ##1 (o_dbg_own == 5'h0F);
  endproperty
  a_no_trst: assert property (p_no_trst) else $error("no-reset setting released wrong pins");

  property p_swd_only;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      (i_reg_wr && i_reg_addr == ADDR_CTRL && i_reg_wdata[1:0] == 2'h2) ##1 (!i_reg_wr)
        |-> ##1 (o_dbg_own == 5'h03);
  endproperty
  a_swd_only: assert property (p_swd_only) else $error("two-wire setting released wrong pins");

  property p_all_released;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      (i_reg_wr && i_reg_addr == ADDR_CTRL && i_reg_wdata[1:0] == 2'h3) ##1 (!i_reg_wr)
        |-> ##1 (o_dbg_own == 5'h00) ##1 (o_dbg_in == 5'h15);
  endproperty
  a_all_released: assert property (p_all_released) else $error("disabled setting kept a pin");

  property p_trace_unassigned;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      (o_dbg_own[3] && ref_reg.core_s2.swd_mode && !ref_reg.core_s2.trace_en) |=> !o_pad.oe[3];
  endproperty
  a_trace_unassigned: assert property (p_trace_unassigned) else $error("trace pin driven unarmed");

  property p_tdo_driven;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      (o_dbg_own[3] && !ref_reg.core_s2.swd_mode) |=> (o_pad.oe[3] && o_pad.out[3] == $past(ref_reg.core_s2.tdo));
  endproperty
  a_tdo_driven: assert property (p_tdo_driven) else $error("data out not driven in jtag mode");

  property p_tms_input_jtag;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      (o_dbg_own[0] && !ref_reg.core_s2.swd_mode) |=> (!o_pad.oe[0] && o_pad.pu[0]);
  endproperty
  a_tms_input_jtag: assert property (p_tms_input_jtag) else $error("mode pin driven in jtag mode");

  property p_clock_pulldown;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      o_dbg_own[1] |=> (o_pad.pd[1] && !o_pad.pu[1] && !o_pad.oe[1]);
  endproperty
  a_clock_pulldown: assert property (p_clock_pulldown) else $error("clock pin lacks pull-down");

  property p_gpio_ignored;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      o_dbg_own[2] |=> (!o_pad.oe[2] && o_pad.pu[2]);
  endproperty
  a_gpio_ignored: assert property (p_gpio_ignored) else $error("gpio reached an owned pin");

  property p_gpio_takes_over;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      (!o_dbg_own[2] && i_gpio_cfg_valid[2]) |=> (o_pad.oe[2] == $past(i_gpio.oe[2]));
  endproperty
  a_gpio_takes_over: assert property (p_gpio_takes_over) else $error("released pin not under gpio");

  property p_gpio_reset_cfg;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      (!o_dbg_own[4] && !i_gpio_cfg_valid[4]) |=> (o_pad.pu[4] && !o_pad.oe[4]);
  endproperty
  a_gpio_reset_cfg: assert property (p_gpio_reset_cfg) else $error("released pin not in reset setup");

  property p_stat_read;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      (i_reg_rd && i_reg_addr == ADDR_STAT) |=> (o_reg_rdata[4:0] == $past(o_dbg_own));
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("status read mismatch");

  // the edge that first sees reset released still shows the reset ownership
  property p_reset_owns;
    @(posedge i_ref_clk)
      $rose(i_arst_n) |-> (o_dbg_own == OWN_FULL && o_pad.oe == '0);
  endproperty
  a_reset_owns: assert property (p_reset_owns) else $error("reset did not give pins to debug");

  property p_swdio_drive;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      (o_dbg_own[PIN_A13] && ref_reg.core_s2.swd_mode) |=> (o_pad.oe[PIN_A13] == $past(ref_reg.core_s2.swdio_oe));
  endproperty
  a_swdio_drive: assert property (p_swdio_drive) else $error("data pin not handed to two-wire core");

  property p_trace_drive;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      (o_dbg_own[PIN_B3] && ref_reg.core_s2.swd_mode && ref_reg.core_s2.trace_en)
        |=> (o_pad.oe[PIN_B3] && o_pad.out[PIN_B3] == $past(ref_reg.core_s2.trace_out));
  endproperty
  a_trace_drive: assert property (p_trace_drive) else $error("armed trace not driven");

  // every owned pin carries the fixed debug pulls, whatever gpio asks for
  property p_dbg_pulls;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      1'b1 |=> ((((o_pad.pu ^ DBG_PU) | (o_pad.pd ^ DBG_PD)) & $past(o_dbg_own)) == '0);
  endproperty
  a_dbg_pulls: assert property (p_dbg_pulls) else $error("owned pin has wrong pulls");

  // owned input-only pins (clock, data in, reset) are never driven
  property p_owned_quiet;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      1'b1 |=> ((o_pad.oe & $past(o_dbg_own) & 5'h16) == '0);
  endproperty
  a_owned_quiet: assert property (p_owned_quiet) else $error("owned input pin driven");

  property p_gpio_vector;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      1'b1 |=> (((o_pad.oe ^ $past(i_gpio.oe)) & ~$past(o_dbg_own) & $past(i_gpio_cfg_valid)) == '0);
  endproperty
  a_gpio_vector: assert property (p_gpio_vector) else $error("released pins not under gpio");

  property p_gpio_reset_pulls;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      1'b1 |=> ((((o_pad.pu ^ GPIO_RST_PU) | (o_pad.pd ^ GPIO_RST_PD) | o_pad.oe)
                 & ~$past(o_dbg_own) & ~$past(i_gpio_cfg_valid)) == '0);
  endproperty
  a_gpio_reset_pulls: assert property (p_gpio_reset_pulls) else $error("released pins off reset setup");

  property p_unmapped_read;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      (i_reg_rd && i_reg_addr != ADDR_CTRL && i_reg_addr != ADDR_STAT) |=> (o_reg_rdata == '0);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  // read data stands for one cycle only, so a stale word never reaches software
  property p_rdata_one_cycle;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      !i_reg_rd |=> (o_reg_rdata == '0);
  endproperty
  a_rdata_one_cycle: assert property (p_rdata_one_cycle) else $error("read data held too long");

  property p_trace_armed_link;
    @(posedge i_link_clk) disable iff (!i_arst_n)
      1'b1 |=> (o_lk_trace_armed == $past(i_dbg_core.trace_en && i_dbg_core.swd_mode));
  endproperty
  a_trace_armed_link: assert property (p_trace_armed_link) else $error("trace arming wrong");

endmodule

// *** hw/dpm_pkg.sv ***
// package: constants and types for the debug port pin release mux
package dpm_pkg;

  // widths of the register port and the shared pin group
  localparam int NPIN = 5;
  localparam int AW   = 4;
  localparam int DW   = 32;

  // register offsets (byte addresses)
  localparam logic [AW-1:0] ADDR_CTRL = 4'h0;
  localparam logic [AW-1:0] ADDR_STAT = 4'h4;

  // field positions
  localparam int CTRL_MODE_LSB  = 0;
  localparam int STAT_OWN_LSB   = 0;
  localparam int STAT_TRACE_BIT = 5;
  localparam int STAT_SWD_BIT   = 6;

  // pin indices inside the shared group
  localparam int PIN_A13 = 0; // port_a_pin_13: test_mode_select_pin / two-wire data
  localparam int PIN_A14 = 1; // port_a_pin_14: test_clock_pin / two-wire clock
  localparam int PIN_A15 = 2; // port_a_pin_15: test_data_in_pin
  localparam int PIN_B3  = 3; // port_b_pin_3: test_data_out_pin / async_trace_output
  localparam int PIN_B4  = 4; // port_b_pin_4: test_reset_pin

  // release settings, in the order software programs them
  typedef enum logic [1:0] {
    REL_FULL,
    REL_NO_TRST,
    REL_SWD_ONLY,
    REL_ALL
  } dpm_rel_e;

  // pins kept by the combined_debug_port in each setting
  localparam logic [NPIN-1:0] OWN_FULL     = 5'h1F;
  localparam logic [NPIN-1:0] OWN_NO_TRST  = 5'h0F;
  localparam logic [NPIN-1:0] OWN_SWD_ONLY = 5'h03;
  localparam logic [NPIN-1:0] OWN_NONE     = 5'h00;

  // pulls while on the debug port, and the gpio reset pulls (data out floats)
  localparam logic [NPIN-1:0] DBG_PU      = 5'h15;
  localparam logic [NPIN-1:0] DBG_PD      = 5'h02;
  localparam logic [NPIN-1:0] GPIO_RST_PU = 5'h15;
  localparam logic [NPIN-1:0] GPIO_RST_PD = 5'h02;
  // level the debug core sees on an input pin it no longer owns
  localparam logic [NPIN-1:0] DBG_IN_IDLE = 5'h15;

  // pad control for the five pins
  typedef struct packed {
    logic [NPIN-1:0] out;
    logic [NPIN-1:0] oe;
    logic [NPIN-1:0] pu;
    logic [NPIN-1:0] pd;
  } dpm_pad_s;

  // debug core signals that cross from the link domain
  typedef struct packed {
    logic swdio_out;
    logic swdio_oe;
    logic tdo;
    logic trace_out;
    logic trace_en;
    logic swd_mode;
  } dpm_core_s;

  // state of the system-clock side
  typedef struct packed {
    dpm_rel_e        mode;
    logic [NPIN-1:0] own;
    logic [NPIN-1:0] pad_s1;
    logic [NPIN-1:0] pad_s2;
    dpm_core_s       core_s1;
    dpm_core_s       core_s2;
    dpm_pad_s        pad;
    logic [NPIN-1:0] gpio_in;
    logic [NPIN-1:0] dbg_in;
    logic [DW-1:0]   rdata;
  } dpm_ref_s;

  // state of the link-clock side
  typedef struct packed {
    logic            trace;
    logic [NPIN-1:0] own_s1;
    logic [NPIN-1:0] own_s2;
  } dpm_link_s;

  localparam dpm_pad_s PAD_RST = '{out: 5'h00, oe: 5'h00, pu: DBG_PU, pd: DBG_PD};

  localparam dpm_ref_s REF_RST = '{
    mode:    REL_FULL,
    own:     OWN_FULL,
    pad_s1:  5'h00,
    pad_s2:  5'h00,
    core_s1: 6'h00,
    core_s2: 6'h00,
    pad:     PAD_RST,
    gpio_in: 5'h00,
    dbg_in:  DBG_IN_IDLE,
    rdata:   32'h0000_0000
  };

  localparam dpm_link_s LINK_RST = '{trace: 1'b0, own_s1: OWN_FULL, own_s2: OWN_FULL};

endpackage

// *** test/dpm_host_model.sv ***
// partner model: debugger host side, presents the debug core levels on the link clock
`timescale 1ns/1ps
module dpm_host_model (
  // link clock and reset
  input  wire logic               i_link_clk,
  input  wire logic               i_arst_n,
  // levels the bench asks the host to present
  input  wire dpm_pkg::dpm_core_s i_req,
  // levels seen by the mux
  output dpm_pkg::dpm_core_s      o_core
);
  import dpm_pkg::*;
  // levels move only on the link clock, so the mux must resync them like a real probe
  // the host has no path to the release setting at all
  always_ff @(posedge i_link_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_core <= '0;
    end else begin
      o_core <= i_req;
    end
  end
endmodule

// *** test/tb_top.sv ***
// testbench: random and corner checks of the debug pin release mux
`timescale 1ns/1ps
module tb_top;
  import dpm_pkg::*;
  logic            clk = 1'b0;
  logic            lclk = 1'b0;
  logic            rst_n = 1'b0;
  logic [AW-1:0]   addr = '0;
  logic [DW-1:0]   wdata = '0;
  logic [DW-1:0]   rdata;
  logic [DW-1:0]   rval;
  logic            wr = 1'b0;
  logic            rd = 1'b0;
  logic [NPIN-1:0] pad_in = '0;
  logic [NPIN-1:0] cfg = '0;
  logic [NPIN-1:0] gin, dbg_in, own, avail, e_own;
  logic            armed;
  logic [1:0]      m;
  logic [31:0]     r1, r2;
  logic [31:0]     seed = 32'h21;
  dpm_pad_s        pad, e;
  dpm_pad_s        gpio = '0;
  dpm_core_s       req = '0;
  dpm_core_s       core;
  int              fails = 0;
  int              check_count = 0;

  // system clock, 100 MHz
  always #5 clk = ~clk;
  // link clock, 64 ns, offset 7 ns so its edges drift across the system clock, some still lining up with it
  initial begin
    #7;
    forever #32 lclk = ~lclk;
  end

  dpm_host_model u_host (.i_link_clk(lclk), .i_arst_n(rst_n), .i_req(req), .o_core(core));

  dpm_pin_mux u_dut (
    .i_ref_clk(clk), .i_link_clk(lclk), .i_arst_n(rst_n),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .i_pad_in(pad_in), .o_pad(pad), .i_gpio(gpio), .i_gpio_cfg_valid(cfg), .o_gpio_in(gin),
    .i_dbg_core(core), .o_dbg_in(dbg_in), .o_dbg_own(own), .o_lk_pin_avail(avail),
    .o_lk_trace_armed(armed)
  );

  // xorshift source, fixed start so a failing run repeats
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // pins the debug port keeps in each release setting
  function automatic logic [NPIN-1:0] own_of(input logic [1:0] s);
    case (s)
      2'h0: return 5'h1F;
      2'h1: return 5'h0F;
      2'h2: return 5'h03;
      default: return 5'h00;
    endcase
  endfunction

  // expected pad control: released pins follow gpio or its reset setup, owned pins the fixed debug pulls, with only pins 0 and 3 driven by the debug core
  function automatic dpm_pad_s exp_pad(input logic [NPIN-1:0] o, input logic [NPIN-1:0] c,
                                       input dpm_pad_s g, input dpm_core_s q);
    dpm_pad_s r;
    r.out = g.out & c & ~o;
    r.oe  = g.oe & c & ~o;
    r.pu  = (((g.pu & c) | (5'h15 & ~c)) & ~o) | (5'h15 & o);
    r.pd  = (((g.pd & c) | (5'h02 & ~c)) & ~o) | (5'h02 & o);
    if (o[0]) begin
      r.oe[0]  = q.swd_mode & q.swdio_oe;
      r.out[0] = q.swdio_out;
    end
    if (o[3]) begin
      r.oe[3]  = !q.swd_mode | q.trace_en;
      r.out[3] = q.swd_mode ? q.trace_out : q.tdo;
    end
    return r;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // bus tasks start right after a rising edge
  task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe, taken before the next edge updates it
  task automatic rd_reg(input logic [AW-1:0] a, output logic [DW-1:0] d);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // watchdog, well beyond the roughly 8 us the sequence needs
  initial begin
    #100000;
    fails++;
    print_verdict();
  end

  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(own, 5'h1F);
    chk(pad.pu, 5'h15);
    chk(pad.pd, 5'h02);
    @(posedge clk);
    rd_reg(ADDR_STAT, rval);
    chk(rval, 32'h0000_001F);
    rd_reg(4'hC, rval);
    chk(rval, 32'h0000_0000);
    wr_reg(4'h8, 32'h0000_0003);
    rd_reg(ADDR_CTRL, rval);
    chk(rval, 32'h0000_0000);
    for (int k = 0; k < 16; k++) begin
      r1 = xs();
      r2 = xs();
      m = (k < 4) ? k[1:0] : r2[17:16];
      gpio   <= r1[19:0];
      cfg    <= (k < 4) ? 5'h00 : r2[4:0];
      pad_in <= r2[9:5];
      req    <= r2[15:10];
      wr_reg(ADDR_CTRL, {30'h0, m});
      repeat (40) @(posedge clk);
      #1;
      e_own = own_of(m);
      e = exp_pad(e_own, cfg, gpio, req);
      chk(own, e_own);
      chk(pad.oe, e.oe);
      chk(pad.out & e.oe, e.out & e.oe);
      chk(pad.pu, e.pu);
      chk(pad.pd, e.pd);
      chk(gin, pad_in);
      chk(dbg_in, (pad_in & e_own) | (5'h15 & ~e_own));
      chk(avail, e_own);
      chk(armed, req.trace_en & req.swd_mode);
      @(posedge clk);
      rd_reg(ADDR_CTRL, rval);
      chk(rval, {30'h0, m});
      rd_reg(ADDR_STAT, rval);
      chk(rval, {25'h0, req.swd_mode, req.trace_en, e_own});
    end
    // mid-run reset from the fully released setting: all pins must return to debug
    wr_reg(ADDR_CTRL, 32'h0000_0003);
    repeat (4) @(posedge clk);
    #1;
    chk(own, 5'h00);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(own, 5'h1F);
    chk(pad.pu, 5'h15);
    chk(pad.pd, 5'h02);
    @(posedge clk);
    rd_reg(ADDR_CTRL, rval);
    chk(rval, 32'h0000_0000);
    print_verdict();
  end
endmodule
